// >>> pkg/fssr_pkg.sv
// Register map, field positions and reset values of the fan source select group
package fssr_pkg;
    localparam logic [7:0] FSSR_ADDR_SUPPLY_LIMIT  = 8'h86;
    localparam logic [7:0] FSSR_ADDR_PWM_MODULE    = 8'h87;
    localparam logic [7:0] FSSR_ADDR_TOPOLOGY      = 8'h88;
    localparam logic [7:0] FSSR_ADDR_OVT_STATUS    = 8'h89;
    localparam logic [7:0] FSSR_ADDR_FAN1_SENSOR   = 8'h8A;
    localparam logic [7:0] FSSR_ADDR_FAN1_BUS      = 8'h8B;
    localparam logic [7:0] FSSR_ADDR_FAN1_PUSHED   = 8'h8C;
    localparam logic [7:0] FSSR_ADDR_FAN2_SENSOR   = 8'h8D;
    localparam logic [7:0] FSSR_ADDR_FAN2_BUS      = 8'h8E;
    localparam logic [7:0] FSSR_ADDR_FAN2_PUSHED   = 8'h8F;

    localparam logic [7:0] FSSR_RST_SUPPLY_LIMIT   = 8'hFF;
    localparam logic [7:0] FSSR_RST_PWM_MODULE     = 8'h00;
    localparam logic [7:0] FSSR_RST_TOPOLOGY       = 8'h00;
    localparam logic [7:0] FSSR_RST_OVT_STATUS     = 8'h00;
    localparam logic [7:0] FSSR_RST_FAN1_SENSOR    = 8'h08;
    localparam logic [7:0] FSSR_RST_FAN_OTHER      = 8'h00;

    // Writable bit masks; the rest reads zero
    localparam logic [7:0] FSSR_WMASK_FULL         = 8'hFF;
    localparam logic [7:0] FSSR_WMASK_PWM_MODULE   = 8'hF7;
    localparam logic [7:0] FSSR_WMASK_TOPOLOGY     = 8'hF8;
    localparam logic [7:0] FSSR_WMASK_SENSOR       = 8'h7F;
    localparam logic [7:0] FSSR_WMASK_PUSHED       = 8'h0F;

    // Field positions
    localparam int FSSR_POS_FAN_OFF_LO    = 0;
    localparam int FSSR_POS_MODULE_LO     = 4;
    localparam int FSSR_POS_DOM_LO        = 3;
    localparam int FSSR_POS_CPU_COUNT_LO  = 6;
    localparam int FSSR_POS_SHUTDOWN_LO   = 4;
    localparam int FSSR_POS_EXTRA_LIMIT   = 7;

    // Number of sources in the max-demand selector
    localparam int FSSR_NUM_SRC  = 19;
    localparam int FSSR_SRC_W    = 5;
    localparam int FSSR_NUM_REGS = 10;
endpackage

// >>> src/fssr_demand_max.sv
// Highest-demand selector over enabled duty requests
`timescale 1ns/100ps
module fssr_demand_max
    import fssr_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // Sources
    input  wire logic [FSSR_NUM_SRC-1:0] src_enable,
    input  wire logic [FSSR_NUM_SRC*8-1:0] src_demand,
    // Result
    output logic      [7:0]              duty,
    output logic                         any_enabled
);
    logic [7:0] stage [FSSR_NUM_SRC+1];
    logic [7:0] duty_q;
    logic       any_q;

    assign stage[0] = 8'h00;
    genvar gi;
    generate
        for (gi = 0; gi < FSSR_NUM_SRC; gi++) begin : g_max
            wire logic [7:0] cand = src_enable[gi] ? src_demand[gi*8 +: 8] : 8'h00;
            assign stage[gi+1] = (cand > stage[gi]) ? cand : stage[gi];
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            duty_q <= 8'h00;
            any_q  <= 1'b0;
        end else begin
            duty_q <= stage[FSSR_NUM_SRC];
            any_q  <= |src_enable;
        end
    end
    assign duty        = duty_q;
    assign any_enabled = any_q;
endmodule

// >>> src/fssr_status_flags.sv
// Over-temperature status byte, live levels sampled each cycle
`timescale 1ns/100ps
module fssr_status_flags
    import fssr_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Conditions
    input  wire logic [3:0] proc_control_temp_exceeded,
    input  wire logic       remote_a_shutdown_exceeded,
    input  wire logic       local_shutdown_exceeded,
    input  wire logic       remote_b_shutdown_exceeded,
    input  wire logic [7:0] extra_limit_status,
    // Status byte
    output logic      [7:0] status
);
    logic [7:0] status_q;
    // Status follows conditions; clearing is owned by the monitors feeding it
    wire logic [7:0] status_d = {|extra_limit_status, remote_b_shutdown_exceeded,
                                 local_shutdown_exceeded, remote_a_shutdown_exceeded,
                                 proc_control_temp_exceeded};
    always_ff @(posedge clock) begin
        if (!rst_n) status_q <= FSSR_RST_OVT_STATUS;
        else        status_q <= status_d;
    end
    assign status = status_q;
endmodule

// >>> src/fssr_regs.sv
// Fan source select register group with supply limit, topology and status
`timescale 1ns/100ps
module fssr_regs
    import fssr_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Register port from the serial slave
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic [7:0]  reg_wr_data,
    input  wire logic        reg_rd_en,
    output logic      [7:0]  reg_rd_data,
    output logic             reg_rd_hit,
    // Per-source duty demands from the loop arithmetic
    input  wire logic [55:0] sensor_demand,
    input  wire logic [63:0] bus_slave_demand,
    input  wire logic [31:0] external_demand,
    // Status conditions
    input  wire logic [3:0]  proc_control_temp_exceeded,
    input  wire logic        remote_a_shutdown_exceeded,
    input  wire logic        local_shutdown_exceeded,
    input  wire logic        remote_b_shutdown_exceeded,
    input  wire logic [7:0]  extra_limit_status,
    // Module temperature forwarding
    input  wire logic [3:0]  module_temp_valid,
    output logic      [3:0]  module_forward,
    // Configuration outputs
    output logic      [7:0]  supply_upper_limit,
    output logic      [2:0]  fan_out_disable,
    output logic      [3:0]  module_present,
    output logic      [2:0]  proc_dual_domain,
    output logic      [1:0]  proc_count,
    // Fan loop results
    output logic      [7:0]  fan1_auto_duty,
    output logic      [7:0]  fan2_auto_duty,
    output logic             fan1_auto_active,
    output logic             fan2_auto_active
);
    // Register storage, indexed by offset from the first address
    logic [7:0] regs_q [FSSR_NUM_REGS];
    logic [7:0] rd_data_q;
    logic       rd_hit_q;
    logic [3:0] fwd_q;
    logic [7:0] status;
    logic [7:0] duty1_raw;
    logic [7:0] duty2_raw;
    logic       act1_raw;
    logic       act2_raw;
    logic [7:0] duty1_q;
    logic [7:0] duty2_q;
    logic       act1_q;
    logic       act2_q;

    function automatic logic [7:0] fssr_wmask(input int idx);
        case (idx)
            0:       fssr_wmask = FSSR_WMASK_FULL;
            1:       fssr_wmask = FSSR_WMASK_PWM_MODULE;
            2:       fssr_wmask = FSSR_WMASK_TOPOLOGY;
            3:       fssr_wmask = 8'h00;
            4, 7:    fssr_wmask = FSSR_WMASK_SENSOR;
            6, 9:    fssr_wmask = FSSR_WMASK_PUSHED;
            default: fssr_wmask = FSSR_WMASK_FULL;
        endcase
    endfunction

    function automatic logic [7:0] fssr_reset(input int idx);
        case (idx)
            0:       fssr_reset = FSSR_RST_SUPPLY_LIMIT;
            1:       fssr_reset = FSSR_RST_PWM_MODULE;
            2:       fssr_reset = FSSR_RST_TOPOLOGY;
            4:       fssr_reset = FSSR_RST_FAN1_SENSOR;
            default: fssr_reset = FSSR_RST_FAN_OTHER;
        endcase
    endfunction

    // Address decode
    wire logic [7:0] addr_off = reg_addr - FSSR_ADDR_SUPPLY_LIMIT;
    wire logic       in_range = (reg_addr >= FSSR_ADDR_SUPPLY_LIMIT) &&
                                (reg_addr <= FSSR_ADDR_FAN2_PUSHED);

    genvar gi;
    generate
        for (gi = 0; gi < FSSR_NUM_REGS; gi++) begin : g_reg
            wire logic       wr_hit = reg_wr_en && in_range && (addr_off == 8'(gi));
            wire logic [7:0] wm     = fssr_wmask(gi);
            wire logic [7:0] nxt    = wr_hit ? (reg_wr_data & wm) : regs_q[gi];
            always_ff @(posedge clock) begin
                if (!rst_n) regs_q[gi] <= fssr_reset(gi);
                else        regs_q[gi] <= nxt;
            end
        end
    endgenerate

    // Status register is hardware owned
    fssr_status_flags u_status (
        .clock                      (clock),
        .rst_n                      (rst_n),
        .proc_control_temp_exceeded (proc_control_temp_exceeded),
        .remote_a_shutdown_exceeded (remote_a_shutdown_exceeded),
        .local_shutdown_exceeded    (local_shutdown_exceeded),
        .remote_b_shutdown_exceeded (remote_b_shutdown_exceeded),
        .extra_limit_status         (extra_limit_status),
        .status                     (status)
    );

    // Read mux; status index reads the live byte
    wire logic [3:0] rd_idx  = addr_off[3:0];
    wire logic [7:0] rd_word = (rd_idx == 4'h3) ? status : regs_q[rd_idx];
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
            rd_hit_q  <= 1'b0;
        end else begin
            rd_data_q <= (reg_rd_en && in_range) ? rd_word : 8'h00;
            rd_hit_q  <= reg_rd_en && in_range;
        end
    end

    // Source enables: sensor bits 6:0, bus bits 7:0, pushed bits 3:0
    wire logic [FSSR_NUM_SRC-1:0] en1 = {regs_q[6][3:0], regs_q[5], regs_q[4][6:0]};
    wire logic [FSSR_NUM_SRC-1:0] en2 = {regs_q[9][3:0], regs_q[8], regs_q[7][6:0]};
    wire logic [FSSR_NUM_SRC*8-1:0] demands = {external_demand, bus_slave_demand, sensor_demand};

    fssr_demand_max u_max1 (
        .clock       (clock),
        .rst_n       (rst_n),
        .src_enable  (en1),
        .src_demand  (demands),
        .duty        (duty1_raw),
        .any_enabled (act1_raw)
    );
    fssr_demand_max u_max2 (
        .clock       (clock),
        .rst_n       (rst_n),
        .src_enable  (en2),
        .src_demand  (demands),
        .duty        (duty2_raw),
        .any_enabled (act2_raw)
    );

    // Disabled outputs park at zero duty
    wire logic [2:0] off_bits = regs_q[1][FSSR_POS_FAN_OFF_LO +: 3];
    wire logic [3:0] present  = regs_q[1][FSSR_POS_MODULE_LO +: 4];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            duty1_q <= 8'h00;
            duty2_q <= 8'h00;
            act1_q  <= 1'b0;
            act2_q  <= 1'b0;
            fwd_q   <= 4'h0;
        end else begin
            duty1_q <= off_bits[0] ? 8'h00 : duty1_raw;
            duty2_q <= off_bits[1] ? 8'h00 : duty2_raw;
            act1_q  <= act1_raw && !off_bits[0];
            act2_q  <= act2_raw && !off_bits[1];
            fwd_q   <= module_temp_valid & present;
        end
    end

    // Config fields, taken straight from register flops
    assign supply_upper_limit = regs_q[0];
    assign fan_out_disable    = off_bits;
    assign module_present     = present;
    assign proc_dual_domain   = {regs_q[2][FSSR_POS_DOM_LO], regs_q[2][FSSR_POS_DOM_LO+1],
                                 regs_q[2][FSSR_POS_DOM_LO+2]};
    assign proc_count         = regs_q[2][FSSR_POS_CPU_COUNT_LO +: 2];
    assign module_forward     = fwd_q;
    assign reg_rd_data        = rd_data_q;
    assign reg_rd_hit         = rd_hit_q;
    assign fan1_auto_duty     = duty1_q;
    assign fan2_auto_duty     = duty2_q;
    assign fan1_auto_active   = act1_q;
    assign fan2_auto_active   = act2_q;

    // Checks
    AST_SUPPLY_RESET: assert property (@(posedge clock) !rst_n |=> regs_q[0] == 8'hFF)
        else $error("supply limit reset value wrong");
    AST_FAN1_RESET: assert property (@(posedge clock) !rst_n |=> regs_q[4] == 8'h08)
        else $error("fan1 sensor select reset wrong");
    AST_CFG_RESET: assert property (@(posedge clock) !rst_n |=> regs_q[1] == 8'h00 && regs_q[2] == 8'h00)
        else $error("config reset wrong");
    AST_FAN_OFF: assert property (@(posedge clock) disable iff (!rst_n)
        off_bits[0] |=> fan1_auto_duty == 8'h00)
        else $error("disabled fan1 has duty");
    AST_FORWARD: assert property (@(posedge clock) disable iff (!rst_n)
        (|(module_forward & ~$past(present))) == 1'b0)
        else $error("absent module forwarded");
    AST_RESERVED: assert property (@(posedge clock) disable iff (!rst_n)
        regs_q[1][3] == 1'b0 && regs_q[2][2:0] == 3'h0 && regs_q[6][7:4] == 4'h0)
        else $error("reserved bit set");
    AST_STATUS_SUM: assert property (@(posedge clock) disable iff (!rst_n)
        |extra_limit_status |=> status[7])
        else $error("summary bit missing");
    AST_SHUTDOWN: assert property (@(posedge clock) disable iff (!rst_n)
        local_shutdown_exceeded |=> status[5])
        else $error("local shutdown flag missing");
    AST_PROC_OVT: assert property (@(posedge clock) disable iff (!rst_n)
        proc_control_temp_exceeded[0] |=> status[0])
        else $error("processor flag missing");
    AST_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
        reg_wr_en && reg_addr == FSSR_ADDR_TOPOLOGY |=> proc_count == $past(reg_wr_data[7:6]))
        else $error("processor count not written");
    AST_MAX: assert property (@(posedge clock) disable iff (!rst_n)
        regs_q[4] == 8'h01 && regs_q[5] == 8'h00 && regs_q[6] == 8'h00 && !off_bits[0]
        ##2 regs_q[4] == 8'h01 |-> fan1_auto_duty == $past(sensor_demand[7:0], 2))
        else $error("single source duty wrong");

    COV_WRITE_LIMIT: cover property (@(posedge clock) reg_wr_en && reg_addr == FSSR_ADDR_SUPPLY_LIMIT);
    COV_READ_STATUS: cover property (@(posedge clock) reg_rd_en && reg_addr == FSSR_ADDR_OVT_STATUS);
    COV_FAN2_ACTIVE: cover property (@(posedge clock) fan2_auto_active);
endmodule

// >>> verif/fssr_host.sv
// Host model that reaches the register port the way the serial slave does
`timescale 1ns/100ps
module fssr_host (
    // Clock
    input  wire logic       clock,
    // Register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            reg_rd_en,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_hit
);
    initial begin
        reg_addr    = 8'h00;
        reg_wr_en   = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en   = 1'b0;
    end

    // One-cycle write strobe; released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_en   <= 1'b1;
        @(posedge clock);
        reg_wr_en   <= 1'b0;
        reg_addr    <= ~a;
        reg_wr_data <= ~d;
    endtask

    // Read data stands one cycle only, so it is taken just after the answering edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge clock);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clock);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        #1;
        d = reg_rd_data;
        h = reg_rd_hit;
    endtask
endmodule

// >>> verif/fssr_regs_tb.sv
// Self-checking testbench of the fan source select register group
`timescale 1ns/100ps
module fssr_regs_tb
    import fssr_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, supply_upper_limit, fan1_auto_duty, fan2_auto_duty;
    logic reg_wr_en, reg_rd_en, reg_rd_hit, fan1_auto_active, fan2_auto_active;
    logic [55:0] sensor_demand = '0;
    logic [63:0] bus_slave_demand = '0;
    logic [31:0] external_demand = '0;
    logic [3:0] proc_control_temp_exceeded = '0, module_temp_valid = '0, module_forward, module_present;
    logic remote_a_shutdown_exceeded = 1'b0, local_shutdown_exceeded = 1'b0, remote_b_shutdown_exceeded = 1'b0;
    logic [7:0] extra_limit_status = '0;
    logic [2:0] fan_out_disable, proc_dual_domain;
    logic [1:0] proc_count;
    int err_total = 0;
    int checks = 0;
    logic [7:0] rdv;
    logic hit;
    logic [7:0] rst_tab [10] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk_tab [10] = '{8'hFF, 8'hF7, 8'hF8, 8'h00, 8'h7F, 8'hFF, 8'h0F, 8'h7F, 8'hFF, 8'h0F};

    always #20 clock = ~clock;

    fssr_host i_host (.clock(clock), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit));

    fssr_regs i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit),
        .sensor_demand(sensor_demand), .bus_slave_demand(bus_slave_demand), .external_demand(external_demand),
        .proc_control_temp_exceeded(proc_control_temp_exceeded),
        .remote_a_shutdown_exceeded(remote_a_shutdown_exceeded), .local_shutdown_exceeded(local_shutdown_exceeded),
        .remote_b_shutdown_exceeded(remote_b_shutdown_exceeded), .extra_limit_status(extra_limit_status),
        .module_temp_valid(module_temp_valid), .module_forward(module_forward),
        .supply_upper_limit(supply_upper_limit), .fan_out_disable(fan_out_disable),
        .module_present(module_present), .proc_dual_domain(proc_dual_domain), .proc_count(proc_count),
        .fan1_auto_duty(fan1_auto_duty), .fan2_auto_duty(fan2_auto_duty),
        .fan1_auto_active(fan1_auto_active), .fan2_auto_active(fan2_auto_active));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Read one register and compare data and hit flag
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
        i_host.rd(a, rdv, hit);
        chk($sformatf("reg %h", a), exp, rdv);
        chk("rd_hit", {7'h00, exp_hit}, {7'h00, hit});
    endtask

    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic results();
        $display("Checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(40 * 3000);
        err_total++;
        results();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        sensor_demand <= {8'h13, 8'h12, 8'h11, 8'h40, 8'h30, 8'h90, 8'h20};
        bus_slave_demand <= {8'hF0, 48'h0, 8'h55};
        external_demand <= {8'hA5, 16'h0, 8'hFE};
        for (int i = 0; i < 10; i++) rchk(FSSR_ADDR_SUPPLY_LIMIT + 8'(i), rst_tab[i], 1'b1);
        rchk(8'h85, 8'h00, 1'b0);
        rchk(8'h90, 8'h00, 1'b0);
        chk("fan1_duty", 8'h40, fan1_auto_duty);
        $display("Test reset values done");
        for (int i = 0; i < 10; i++) i_host.wr(FSSR_ADDR_SUPPLY_LIMIT + 8'(i), 8'hFF);
        for (int i = 0; i < 10; i++) rchk(FSSR_ADDR_SUPPLY_LIMIT + 8'(i), msk_tab[i], 1'b1);
        chk("disable", 8'h07, {5'h0, fan_out_disable});
        chk("present", 8'h0F, {4'h0, module_present});
        chk("dual_dom", 8'h07, {5'h0, proc_dual_domain});
        chk("fan1_off", 8'h00, fan1_auto_duty);
        chk("fan1_act", 8'h00, {7'h0, fan1_auto_active});
        for (int c = 0; c < 4; c++) begin
            i_host.wr(FSSR_ADDR_TOPOLOGY, {2'(c), 6'h10});
            settle();
            chk("count", 8'(c), {6'h0, proc_count});
            chk("dom_mid", 8'h02, {5'h0, proc_dual_domain});
        end
        $display("Test masks and fields done");
        for (int b = 0; b < 8; b++) begin
            proc_control_temp_exceeded <= (b < 4) ? 4'(1 << b) : 4'h0;
            remote_a_shutdown_exceeded <= (b == 4);
            local_shutdown_exceeded    <= (b == 5);
            remote_b_shutdown_exceeded <= (b == 6);
            extra_limit_status         <= (b == 7) ? 8'h40 : 8'h00;
            settle();
            rchk(FSSR_ADDR_OVT_STATUS, 8'(1 << b), 1'b1);
        end
        $display("Test status done");
        i_host.wr(FSSR_ADDR_PWM_MODULE, 8'h50);
        module_temp_valid <= 4'hF;
        settle();
        chk("forward", 8'h05, {4'h0, module_forward});
        i_host.wr(FSSR_ADDR_FAN1_SENSOR, 8'h07);
        i_host.wr(FSSR_ADDR_FAN1_BUS, 8'h00);
        i_host.wr(FSSR_ADDR_FAN1_PUSHED, 8'h00);
        i_host.wr(FSSR_ADDR_FAN2_SENSOR, 8'h00);
        i_host.wr(FSSR_ADDR_FAN2_BUS, 8'h01);
        i_host.wr(FSSR_ADDR_FAN2_PUSHED, 8'h08);
        settle();
        chk("fan1_max", 8'h90, fan1_auto_duty);
        chk("fan2_max", 8'hA5, fan2_auto_duty);
        chk("fan2_act", 8'h01, {7'h0, fan2_auto_active});
        i_host.wr(FSSR_ADDR_FAN1_BUS, 8'h80);
        settle();
        chk("fan1_bus", 8'hF0, fan1_auto_duty);
        i_host.wr(FSSR_ADDR_FAN1_PUSHED, 8'h01);
        settle();
        chk("fan1_push", 8'hFE, fan1_auto_duty);
        $display("Test fan sources done");
        i_host.wr(FSSR_ADDR_SUPPLY_LIMIT, 8'h5A);
        i_host.wr(FSSR_ADDR_FAN1_SENSOR, 8'h01);
        i_host.wr(FSSR_ADDR_FAN1_BUS, 8'h00);
        i_host.wr(FSSR_ADDR_FAN1_PUSHED, 8'h00);
        settle();
        chk("supply", 8'h5A, supply_upper_limit);
        rchk(FSSR_ADDR_SUPPLY_LIMIT, 8'h5A, 1'b1);
        chk("fan1_local", 8'h20, fan1_auto_duty);
        $display("Test limit and single source done");
        results();
    end
endmodule
